// File: lrc_pkg.sv
package lrc_pkg;
    // Register indices on the serial link
    localparam logic [7:0] IDX_RESULT = 8'h00;
    localparam logic [7:0] IDX_CONFIG = 8'h01;
    // Reset values
    localparam logic [15:0] RESULT_RST = 16'h0000;
    localparam logic [15:0] CONFIG_RST = 16'hc810;
    // Result word layout
    localparam int RES_EXP_LSB = 12;
    localparam int RES_MANT_W = 12;
    // Configuration word layout
    localparam int CFG_RANGE_LSB = 12;
    localparam int CFG_LONG_BIT = 11;
    localparam int CFG_MODE_LSB = 9;
    localparam int CFG_OVF_BIT = 8;
    localparam int CFG_DONE_BIT = 7;
    localparam int CFG_ABOVE_BIT = 6;
    localparam int CFG_BELOW_BIT = 5;
    localparam int CFG_MASK_BIT = 2;
    // Bits the host may write; 8 to 5 are status
    localparam logic [15:0] CFG_WR_MASK = 16'hfe1f;
    // Range codes
    localparam logic [3:0] RANGE_MIN = 4'h0;
    localparam logic [3:0] RANGE_MAX = 4'hb;
    localparam logic [3:0] RANGE_AUTO = 4'hc;
    // Conversion modes
    localparam logic [1:0] MODE_OFF = 2'h0;
    localparam logic [1:0] MODE_SINGLE = 2'h1;
    // Step size of range code 0, in units of 0.01 lux
    localparam int STEP0_CENTILUX = 1;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_CONV = 2'b10
    } lrc_state_t;

    typedef struct packed {
        logic [15:0] cfg;
        logic [15:0] result;
        logic [7:0] ptr;
        logic phase;
        logic [7:0] wr_msb;
        logic [15:0] snap;
        lrc_state_t st;
        logic [3:0] range;
        logic ovf_seen;
        logic ovf;
        logic conversion_done_flag;
        logic start;
        logic abort;
        logic [7:0] rd_data;
        logic rd_valid;
    } lrc_regs_t;

    // Manual range codes lie below the automatic code
    function automatic logic is_manual(input logic [3:0] sel);
        is_manual = (sel < RANGE_AUTO);
    endfunction

    // Step size of a range code in 0.01 lux, doubling per code
    function automatic int step_centilux(input logic [3:0] code);
        step_centilux = STEP0_CENTILUX << code;
    endfunction
endpackage

// File: lrc_result_config.sv
// Summary of operation
// - Result word is exponent in bits 15..12, mantissa in 11..0.
// - Each completed conversion overwrites the stored result word.
// - Exponent codes 0..11 are doubling ranges, step 0.01 to 20.48 lux.
// - Mantissa is an unsigned count from zero to full scale.
// - Mask set with manual range reports exponent field as zero.
// - A configuration write abandons a running conversion at once.
// - After that write a fresh conversion starts if the mode asks.
// - Range selection uses the same code mapping as the exponent.
// - Range code 1100b selects automatic full-scale ranging.
// - Automatic ranging reports the range actually used in exponent.
// - Configuration word at index 01h resets to C810h.
// - Result at index 00h is read-only and resets to zero.
// - Range selection holds automatic code 1100 after power-up.
// - Config bits 15..9 and 4..0 writable; bits 8..5 ignore writes.
// - Registers move as two bytes, more significant byte first.
// - Register pointer is kept until the host writes a new one.
// - Mode 00 shuts down, 01 converts once, 10 or 11 continuously.
// - Auto overflow below maximum range steps up and restarts.
`timescale 1ns/1ps
`default_nettype none
module lrc_result_config
    import lrc_pkg::*;
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_sys_rst,
    // Byte port from the serial engine
    input wire logic i_xfer_start,
    input wire logic i_ptr_valid,
    input wire logic [7:0] i_ptr,
    input wire logic i_wr_valid,
    input wire logic [7:0] i_wr_data,
    input wire logic i_rd_req,
    output logic [7:0] o_rd_data,
    output logic o_rd_valid,
    // Limit comparator status
    input wire logic i_above_limit_flag,
    input wire logic i_below_limit_flag,
    // Light converter
    input wire logic i_conv_done,
    input wire logic [RES_MANT_W-1:0] i_conv_mant,
    input wire logic i_conv_ovf,
    output logic o_conv_start,
    output logic o_conv_abort,
    output logic [3:0] o_conv_range,
    output logic o_integration_length_sel
);
    lrc_regs_t q;
    lrc_regs_t n;
    logic commit;
    logic restart;
    logic [3:0] sel;
    logic [15:0] rd_word;
    logic [3:0] exp_out;

    always_comb begin
        n = q;
        n.start = 1'b0;
        n.abort = 1'b0;
        n.rd_valid = 1'b0;
        commit = 1'b0;
        sel = q.cfg[CFG_RANGE_LSB +: 4];
        rd_word = (q.ptr == IDX_CONFIG) ?
            {q.cfg[15:9], q.ovf, q.conversion_done_flag, i_above_limit_flag,
             i_below_limit_flag, q.cfg[4:0]} :
            ((q.ptr == IDX_RESULT) ? q.result : 16'h0000);
        exp_out = (is_manual(sel) && q.cfg[CFG_MASK_BIT]) ? RANGE_MIN :
            q.range;
        restart = i_conv_ovf && !is_manual(sel) && (q.range < RANGE_MAX);
        if (i_xfer_start) begin
            n.phase = 1'b0;
        end else if (i_ptr_valid) begin
            n.ptr = i_ptr;
            n.phase = 1'b0;
        end else if (i_wr_valid) begin
            n.phase = ~q.phase;
            if (!q.phase) begin
                n.wr_msb = i_wr_data;
            end else if (q.ptr == IDX_CONFIG) begin
                commit = 1'b1;
            end
        end else if (i_rd_req) begin
            n.rd_valid = 1'b1;
            n.phase = ~q.phase;
            if (!q.phase) begin
                n.snap = rd_word;
                n.rd_data = rd_word[15:8];
                if (q.ptr == IDX_CONFIG) begin
                    n.conversion_done_flag = 1'b0;
                end
            end else begin
                n.rd_data = q.snap[7:0];
            end
        end
        if (commit) begin
            n.cfg = (q.cfg & ~CFG_WR_MASK) |
                ({q.wr_msb, i_wr_data} & CFG_WR_MASK);
            if (q.st == ST_CONV) begin
                n.abort = 1'b1;
            end
            n.st = ST_IDLE;
        end else begin
            unique case (q.st)
                ST_IDLE: begin
                    if (q.cfg[CFG_MODE_LSB +: 2] != MODE_OFF) begin
                        n.st = ST_CONV;
                        n.start = 1'b1;
                        n.ovf_seen = 1'b0;
                        n.range = is_manual(sel) ? sel : RANGE_MIN;
                    end
                end
                ST_CONV: begin
                    if (restart) begin
                        n.abort = 1'b1;
                        n.start = 1'b1;
                        n.range = q.range + 4'h1;
                    end else if (i_conv_done) begin
                        n.result = {exp_out, i_conv_mant};
                        n.ovf = q.ovf_seen | i_conv_ovf;
                        n.conversion_done_flag = 1'b1;
                        n.st = ST_IDLE;
                        if (q.cfg[CFG_MODE_LSB +: 2] == MODE_SINGLE) begin
                            n.cfg[CFG_MODE_LSB +: 2] = MODE_OFF;
                        end
                    end else if (i_conv_ovf) begin
                        n.ovf_seen = 1'b1;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            q.cfg <= CONFIG_RST;
            q.result <= RESULT_RST;
            q.ptr <= IDX_RESULT;
            q.phase <= 1'b0;
            q.wr_msb <= 8'h00;
            q.snap <= 16'h0000;
            q.st <= ST_IDLE;
            q.range <= RANGE_MIN;
            q.ovf_seen <= 1'b0;
            q.ovf <= 1'b0;
            q.conversion_done_flag <= 1'b0;
            q.start <= 1'b0;
            q.abort <= 1'b0;
            q.rd_data <= 8'h00;
            q.rd_valid <= 1'b0;
        end else begin
            q <= n;
        end
    end

    assign o_rd_data = q.rd_data;
    assign o_rd_valid = q.rd_valid;
    assign o_conv_start = q.start;
    assign o_conv_abort = q.abort;
    assign o_conv_range = q.range;
    assign o_integration_length_sel = q.cfg[CFG_LONG_BIT];

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);

    sequence conv_write_s;
        i_wr_valid && !i_xfer_start && !i_ptr_valid && q.phase &&
            q.ptr == IDX_CONFIG;
    endsequence

    sequence rd_msb_s;
        i_rd_req && !i_xfer_start && !i_ptr_valid && !i_wr_valid &&
            !q.phase;
    endsequence

    sequence rd_lsb_s;
        i_rd_req && !i_xfer_start && !i_ptr_valid && !i_wr_valid &&
            q.phase;
    endsequence

    sequence capture_s;
        q.st == ST_CONV && i_conv_done && !restart && !commit;
    endsequence

    sequence launch_s;
        q.st == ST_IDLE && q.cfg[CFG_MODE_LSB +: 2] != MODE_OFF && !commit;
    endsequence

    write_abort_a: assert property (
        (conv_write_s and q.st == ST_CONV) |=> o_conv_abort &&
        q.st == ST_IDLE)
        else $error("write did not abort conversion");
    write_restart_a: assert property (
        conv_write_s ##1 (q.cfg[CFG_MODE_LSB +: 2] != MODE_OFF) |=>
        o_conv_start)
        else $error("no fresh conversion after write");
    status_bits_a: assert property (
        conv_write_s |=> q.cfg[8:5] == $past(q.cfg[8:5]))
        else $error("status bits changed by write");
    cfg_write_a: assert property (
        conv_write_s |=> (q.cfg & CFG_WR_MASK) ==
        ($past({q.wr_msb, i_wr_data}) & CFG_WR_MASK))
        else $error("writable bits not taken");
    cfg_hold_a: assert property (
        (!commit && !(q.st == ST_CONV && i_conv_done)) |=>
        q.cfg == $past(q.cfg))
        else $error("config changed without write");
    result_update_a: assert property (
        capture_s |=> q.result[11:0] == $past(i_conv_mant))
        else $error("result not updated");
    result_hold_a: assert property (
        !(q.st == ST_CONV && i_conv_done) |=> q.result == $past(q.result))
        else $error("result changed without conversion");
    result_word_a: assert property (
        capture_s |=> q.result == {$past(exp_out), $past(i_conv_mant)})
        else $error("result word torn");
    exp_mask_a: assert property (
        (capture_s and (q.cfg[CFG_MASK_BIT] && is_manual(sel))) |=>
        q.result[RES_EXP_LSB +: 4] == RANGE_MIN)
        else $error("masked exponent not zero");
    exp_auto_a: assert property (
        (capture_s and !is_manual(sel)) |=>
        q.result[RES_EXP_LSB +: 4] == $past(q.range))
        else $error("auto exponent not the used range");
    exp_range_a: assert property (
        step_centilux(q.result[RES_EXP_LSB +: 4]) <=
        step_centilux(RANGE_MAX))
        else $error("exponent beyond maximum range");
    range_max_a: assert property (
        o_conv_range <= RANGE_MAX)
        else $error("range beyond maximum");
    manual_range_a: assert property (
        (launch_s and is_manual(sel)) |=> o_conv_start &&
        o_conv_range == $past(sel))
        else $error("manual range not applied");
    auto_first_a: assert property (
        (launch_s and !is_manual(sel)) |=> o_conv_start &&
        o_conv_range == RANGE_MIN)
        else $error("auto ranging did not start low");
    auto_step_a: assert property (
        (q.st == ST_CONV && restart && !commit) |=> o_conv_abort &&
        o_conv_start && o_conv_range == $past(q.range) + 4'h1)
        else $error("auto range did not step up");
    auto_top_a: assert property (
        (q.st == ST_CONV && i_conv_ovf && q.range == RANGE_MAX) |=>
        !o_conv_start)
        else $error("range stepped past maximum");
    ovf_flag_a: assert property (
        capture_s |=> q.ovf == $past(q.ovf_seen || i_conv_ovf))
        else $error("overflow flag not set at end");
    off_idle_a: assert property (
        (q.st == ST_IDLE && q.cfg[CFG_MODE_LSB +: 2] == MODE_OFF) |=>
        !o_conv_start)
        else $error("conversion started while shut down");
    single_end_a: assert property (
        (capture_s and q.cfg[CFG_MODE_LSB +: 2] == MODE_SINGLE) |=>
        q.cfg[CFG_MODE_LSB +: 2] == MODE_OFF ##1 !o_conv_start)
        else $error("single shot did not shut down");
    rd_order_a: assert property (
        rd_lsb_s |=> o_rd_valid && o_rd_data == $past(q.snap[7:0]))
        else $error("read bytes out of order");
    rd_result_a: assert property (
        (rd_msb_s and q.ptr == IDX_RESULT) |=> o_rd_valid &&
        o_rd_data == $past(q.result[15:8]))
        else $error("result msb not sent first");
    ptr_hold_a: assert property (
        !i_ptr_valid |=> q.ptr == $past(q.ptr))
        else $error("pointer changed without write");
    reset_load_a: assert property (
        disable iff (1'b0) i_sys_rst |=> q.cfg == CONFIG_RST &&
        q.result == RESULT_RST)
        else $error("reset values not loaded");
endmodule // lrc_result_config
`default_nettype wire

// File: lrc_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module lrc_host_model
    import lrc_pkg::*;
(
    // Clock
    input wire logic i_clk,
    // Byte port
    input wire logic [7:0] i_rd_data,
    input wire logic i_rd_valid,
    output logic o_xfer_start,
    output logic o_ptr_valid,
    output logic o_wr_valid,
    output logic o_rd_req,
    output logic [7:0] o_byte,
    output logic o_hang
);
    initial begin
        {o_xfer_start, o_ptr_valid, o_wr_valid, o_rd_req, o_hang} = '0;
        o_byte = 8'h00;
    end
    task automatic put(input logic [3:0] k, input logic [7:0] b);
        @(posedge i_clk);
        {o_xfer_start, o_ptr_valid, o_wr_valid, o_rd_req} <= k;
        o_byte <= b;
        @(posedge i_clk);
        {o_xfer_start, o_ptr_valid, o_wr_valid, o_rd_req} <= 4'h0;
        // Released data shows the inverse, not the last value
        o_byte <= ~b;
    endtask
    task automatic get(output logic [7:0] b);
        int i;
        put(4'h1, 8'h00);
        for (i = 0; i < 8; i++) begin
            #1;
            if (i_rd_valid === 1'b1) break;
            @(posedge i_clk);
        end
        if (i == 8) o_hang = 1'b1;
        b = i_rd_data;
    endtask
    task automatic wr_reg(input logic [7:0] idx, input logic [15:0] d);
        if (idx == IDX_CONFIG && d[15:12] > RANGE_AUTO) o_hang = 1'b1;
        put(4'h8, 8'h00);
        put(4'h4, idx);
        put(4'h2, d[15:8]);
        put(4'h2, d[7:0]);
    endtask
    task automatic rd_reg(input logic [7:0] idx, input logic np,
                          output logic [15:0] d);
        put(4'h8, 8'h00);
        if (np) put(4'h4, idx);
        get(d[15:8]);
        get(d[7:0]);
    endtask
endmodule // lrc_host_model
`default_nettype wire

// File: test_light_result_and_range_config.sv
`timescale 1ns/1ps
`default_nettype none
module test_light_result_and_range_config
    import lrc_pkg::*;
;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic done = 1'b0;
    logic ovf = 1'b0;
    logic [11:0] mant = 12'h000;
    logic xs, pv, wv, rr, hang, rv, cs, ca, cl;
    logic [7:0] bt, rd;
    logic [3:0] cr;
    logic [15:0] v;
    int n_errors = 0;
    int num_checks = 0;
    always #12.5 clk = ~clk;
    lrc_host_model host_u (.i_clk(clk), .i_rd_data(rd), .i_rd_valid(rv),
        .o_xfer_start(xs), .o_ptr_valid(pv), .o_wr_valid(wv),
        .o_rd_req(rr), .o_byte(bt), .o_hang(hang));
    lrc_result_config dut_u (.i_clk(clk), .i_sys_rst(rst),
        .i_xfer_start(xs), .i_ptr_valid(pv), .i_ptr(bt), .i_wr_valid(wv),
        .i_wr_data(bt), .i_rd_req(rr), .o_rd_data(rd), .o_rd_valid(rv),
        .i_above_limit_flag(1'b0), .i_below_limit_flag(1'b0),
        .i_conv_done(done), .i_conv_mant(mant), .i_conv_ovf(ovf),
        .o_conv_start(cs), .o_conv_abort(ca), .o_conv_range(cr),
        .o_integration_length_sel(cl));
    task automatic wrap_up();
        $display("TB: checks %0d mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    always @(posedge hang) begin
        n_errors++;
        $display("MISMATCH t=%0t host model gave up", $time);
        wrap_up();
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    // Wait for a start (sel 0) or abort (sel 1) pulse
    task automatic wait_out(input logic sel);
        int i;
        for (i = 0; i < 40; i++) begin
            #1;
            if ((sel ? ca : cs) === 1'b1) break;
            @(posedge clk);
        end
        if (i == 40) begin
            n_errors++;
            $display("MISMATCH t=%0t output wait ran out", $time);
            wrap_up();
        end
    endtask
    task automatic conv(input logic [11:0] m, input logic o);
        @(posedge clk);
        done <= ~o;
        ovf <= o;
        mant <= m;
        @(posedge clk);
        done <= 1'b0;
        ovf <= 1'b0;
        mant <= ~m;
    endtask
    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        host_u.rd_reg(IDX_CONFIG, 1'b1, v);
        chk(v, 16'hc810);
        chk({15'h0, cl}, 16'h0001);
        host_u.rd_reg(IDX_RESULT, 1'b1, v);
        chk(v, 16'h0000);
        host_u.wr_reg(IDX_RESULT, 16'h1234);
        host_u.rd_reg(IDX_RESULT, 1'b0, v);
        chk(v, 16'h0000);
        host_u.wr_reg(IDX_CONFIG, 16'h39ff);
        host_u.rd_reg(IDX_CONFIG, 1'b0, v);
        chk(v, 16'h381f);
        host_u.rd_reg(IDX_CONFIG, 1'b0, v);
        chk(v, 16'h381f);
        $display("TB: test regs done");
        host_u.wr_reg(IDX_CONFIG, 16'h5a00);
        wait_out(1'b0);
        chk({12'h0, cr}, 16'h0005);
        conv(12'h456, 1'b0);
        host_u.rd_reg(IDX_RESULT, 1'b1, v);
        chk(v, 16'h5456);
        host_u.rd_reg(IDX_CONFIG, 1'b1, v);
        chk(v, 16'h5880);
        host_u.wr_reg(IDX_CONFIG, 16'h3a04);
        wait_out(1'b0);
        conv(12'hfff, 1'b0);
        host_u.rd_reg(IDX_RESULT, 1'b1, v);
        chk(v, 16'h0fff);
        $display("TB: test manual done");
        host_u.wr_reg(IDX_CONFIG, 16'hc200);
        wait_out(1'b0);
        chk({12'h0, cr}, 16'h0000);
        for (int k = 1; k < 12; k++) begin
            conv(12'h000, 1'b1);
            wait_out(1'b0);
            chk({ca, 11'h0, cr}, {1'b1, 11'h0, 4'(k)});
        end
        // Overflow at the top range must not step again
        conv(12'h000, 1'b1);
        #1;
        chk({ca, cs, 10'h0, cr}, 16'h000b);
        conv(12'h89a, 1'b0);
        host_u.rd_reg(IDX_RESULT, 1'b1, v);
        chk(v, 16'hb89a);
        host_u.rd_reg(IDX_CONFIG, 1'b1, v);
        chk(v, 16'hc180);
        chk({15'h0, cl}, 16'h0000);
        $display("TB: test auto done");
        host_u.wr_reg(IDX_CONFIG, 16'h7c00);
        wait_out(1'b0);
        host_u.wr_reg(IDX_CONFIG, 16'h7c00);
        wait_out(1'b1);
        wait_out(1'b0);
        conv(12'h123, 1'b0);
        host_u.rd_reg(IDX_RESULT, 1'b1, v);
        chk(v, 16'h7123);
        host_u.wr_reg(IDX_CONFIG, 16'h7800);
        wait_out(1'b1);
        repeat (10) begin
            @(posedge clk);
            #1;
            chk({15'h0, cs}, 16'h0000);
        end
        $display("TB: test abort done");
        wrap_up();
    end
endmodule // test_light_result_and_range_config
`default_nettype wire
